// ---- hdl/analog_comparator_control.sv ----
// Behaviour
// RULE_01 - Enable bit gates comparator operation
// RULE_02 - Two-bit field selects inverting source
// RULE_03 - Reference bit low selects pin A
// RULE_04 - Reference bit high selects ladder voltage
// RULE_05 - Status bits 0..2 read-only outputs
// RULE_06 - Output enable routes result to pin
// RULE_07 - High when noninverting exceeds inverting
// RULE_08 - Polarity bit inverts status and pin
// RULE_09 - Software configures selected pin as input
// RULE_10 - Two-flop synchroniser on comparator outputs
`timescale 1ns/1ps
`default_nettype none
`include "comparator_cfg.svh"
// Register map
//   Word 0x00 holds the control byte of comparator 1
//   Word 0x04 holds the control byte of comparator 2
//   Word 0x08 holds the control byte of comparator 3
//   Word 0x0C holds the shared output status, read only
//   Any other word is refused with an error pulse
// Control byte layout
//   Bit 7 turns the comparator on
//   Bit 6 hands the routed pin over to the result
//   Bit 5 inverts the result polarity
//   Bits 4..3 are spare and always read zero
//   Bit 2 picks the ladder voltage for the plus side
//   Bits 1..0 pick the minus side source
// Minus side codes
//   00 first external pin, 01 second, 10 third
//   11 the internal fixed reference
// Status byte layout
//   Bit 0 result of comparator 1
//   Bit 1 result of comparator 2
//   Bit 2 result of comparator 3
//   Bits 7..3 read zero
// Analog side
//   The analog front end offers every pairing at once
//   Each raw input already says plus beats minus
//   This block only steers, gates and synchronises them
//   Steering outputs tell the front end which pair is live
// Timing
//   Raw results are asynchronous and pass two flops first
//   Status reflects a raw change two edges later
//   The routed pin follows one edge after status, three edges later
//   Control writes land on the edge the request is taken
// Bus behaviour
//   Every answer comes one cycle after the request
//   Ack and error are one-cycle pulses
//   Read data stays put until the next request
//   Only byte lane 0 carries register data
//   Writes with lane 0 off are answered but dropped
//   Writes to the status word are answered but dropped
// Hazards
//   A disabled comparator reads as zero before polarity
//   So polarity alone can make a disabled one read high
//   Software must make the chosen minus pin an input
//   Otherwise the digital driver fights the analog level
// Limits
//   No interrupt and no edge capture live here
//   Result glitches shorter than a cycle may be missed
module analog_comparator_control (
  input  wire logic       clk,
  input  wire logic       rstn,
  // Wishbone classic slave
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]     wb_dat_o,
  output logic            wb_ack_o,
  output logic            wb_err_o,
  // Raw analog comparator results, one per comparator and input pair
  input  wire logic [2:0] raw_gt_b,
  input  wire logic [2:0] raw_gt_c,
  input  wire logic [2:0] raw_gt_d,
  input  wire logic [2:0] raw_gt_fixed,
  input  wire logic [2:0] raw_ladder_gt_b,
  input  wire logic [2:0] raw_ladder_gt_c,
  input  wire logic [2:0] raw_ladder_gt_d,
  input  wire logic [2:0] raw_ladder_gt_fixed,
  // Analog steering controls
  output logic [2:0]      comparator_on,
  output logic [5:0]      inverting_input_select,
  output logic [2:0]      noninverting_ref_select,
  // Remappable pin multiplexers
  input  wire logic [2:0] pin_normal_out,
  output logic [2:0]      output_pin_enable,
  output logic [2:0]      remappable_pin_out
);

  logic [7:0]  ctrl [0:2];      // Control registers
  logic [2:0]  raw_result;      // Selected raw comparison
  logic [2:0]  sync_first;      // Synchroniser stage one
  logic [2:0]  sync_second;     // Synchroniser stage two
  logic [2:0]  result;          // Polarity-adjusted result
  logic        access;          // Valid bus request
  logic [31:0] next_rdata;      // Read mux
  logic        addr_ok;         // Mapped address

  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;

  // Per-comparator datapath
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_cmp
      comparator_pkg::inv_select_type sel;
      logic                           ref_bit;
      logic                           on_bit;
      logic                           gt_pin;
      logic                           gt_ladder;
      assign sel     = comparator_pkg::inv_select_type'(ctrl[i][`CMP_SEL_HI:`CMP_SEL_LO]);
      assign ref_bit = ctrl[i][`CMP_REF_BIT];
      assign on_bit  = ctrl[i][`CMP_ON_BIT];
      // Inverting source choice, pin A on noninverting side
      always_comb begin
        gt_pin    = 1'b0;
        gt_ladder = 1'b0;
        unique case (sel)
          comparator_pkg::sel_input_b: begin
            gt_pin    = raw_gt_b[i]; // RULE_02
            gt_ladder = raw_ladder_gt_b[i];
          end
          comparator_pkg::sel_input_c: begin
            gt_pin    = raw_gt_c[i]; // RULE_02
            gt_ladder = raw_ladder_gt_c[i];
          end
          comparator_pkg::sel_input_d: begin
            gt_pin    = raw_gt_d[i]; // RULE_02
            gt_ladder = raw_ladder_gt_d[i];
          end
          comparator_pkg::sel_fixed_ref: begin
            gt_pin    = raw_gt_fixed[i]; // RULE_02
            gt_ladder = raw_ladder_gt_fixed[i];
          end
        endcase
      end
      // Noninverting source, gated by enable; high when plus exceeds minus
      assign raw_result[i] = on_bit & (ref_bit ? gt_ladder : gt_pin); // RULE_01 RULE_03 RULE_04 RULE_07
      // Polarity applies to status and pin alike
      assign result[i] = sync_second[i] ^ ctrl[i][`CMP_POL_BIT]; // RULE_08
      // Analog steering outputs
      assign comparator_on[i]                  = on_bit; // RULE_01
      assign inverting_input_select[2*i +: 2]  = ctrl[i][`CMP_SEL_HI:`CMP_SEL_LO]; // RULE_02
      assign noninverting_ref_select[i]        = ref_bit; // RULE_03 RULE_04
      assign output_pin_enable[i]              = ctrl[i][`CMP_OE_BIT];
    end
  endgenerate

  // Two-flop synchroniser into the system clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_first  <= 3'h0;
      sync_second <= 3'h0;
    end else begin
      sync_first  <= raw_result;  // RULE_10
      sync_second <= sync_first;  // RULE_10
    end
  end

  // Remappable pin output multiplexer, registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      remappable_pin_out <= 3'h0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        remappable_pin_out[k] <= ctrl[k][`CMP_OE_BIT] ? result[k] : pin_normal_out[k]; // RULE_06
      end
    end
  end

  // Control register writes, byte lane 0 only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl[0] <= `CMP_CTRL_RESET;
      ctrl[1] <= `CMP_CTRL_RESET;
      ctrl[2] <= `CMP_CTRL_RESET;
    end else if (access && wb_we_i && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        `CMP_CTRL1_ADDR: ctrl[0] <= wb_dat_i[7:0] & `CMP_CTRL_MASK;
        `CMP_CTRL2_ADDR: ctrl[1] <= wb_dat_i[7:0] & `CMP_CTRL_MASK;
        `CMP_CTRL3_ADDR: ctrl[2] <= wb_dat_i[7:0] & `CMP_CTRL_MASK;
        default: begin
          // Status is read-only; writes are ignored
        end // RULE_05
      endcase
    end
  end

  // Address decode and read mux
  always_comb begin
    next_rdata = 32'h0;
    addr_ok    = 1'b1;
    case (wb_adr_i)
      `CMP_CTRL1_ADDR:  next_rdata = {24'h0, ctrl[0]};
      `CMP_CTRL2_ADDR:  next_rdata = {24'h0, ctrl[1]};
      `CMP_CTRL3_ADDR:  next_rdata = {24'h0, ctrl[2]};
      `CMP_STATUS_ADDR: next_rdata = {29'h0, result}; // RULE_05
      default:          addr_ok    = 1'b0;
    endcase
  end

  // Bus answer one cycle after request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= access & addr_ok;
      wb_err_o <= access & ~addr_ok;
      if (access) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

endmodule : analog_comparator_control
`default_nettype wire

// ---- hdl/comparator_cfg.svh ----
`ifndef COMPARATOR_CFG_SVH
`define COMPARATOR_CFG_SVH
// Register byte addresses (word aligned)
`define CMP_CTRL1_ADDR   8'h00
`define CMP_CTRL2_ADDR   8'h04
`define CMP_CTRL3_ADDR   8'h08
`define CMP_STATUS_ADDR  8'h0C
// Control field positions
`define CMP_ON_BIT       7
`define CMP_OE_BIT       6
`define CMP_POL_BIT      5
`define CMP_REF_BIT      2
`define CMP_SEL_HI       1
`define CMP_SEL_LO       0
// Reset values
`define CMP_CTRL_RESET   8'h00
// Writable bits of a control register
`define CMP_CTRL_MASK    8'hE7
`endif

// ---- hdl/comparator_pkg.sv ----
package comparator_pkg;
  // Inverting input source codes
  typedef enum logic [1:0] {
    sel_input_b   = 2'b00,
    sel_input_c   = 2'b01,
    sel_input_d   = 2'b10,
    sel_fixed_ref = 2'b11
  } inv_select_type;
endpackage : comparator_pkg

// ---- sim/analog_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Far side: pin A high, other sources high or low
module analog_source_model (
  input  wire logic [4:0]  level,
  output logic      [23:0] raw
);
  // Selected pins act as analog inputs; plus wins only over a low minus
  for (genvar k = 0; k < 4; k++) begin : g_src
    assign raw[3*k+:3]    = {3{~level[k]}};
    assign raw[12+3*k+:3] = {3{level[4] & ~level[k]}};
  end
endmodule : analog_source_model
`default_nettype wire

// ---- sim/analog_comparator_control_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module analog_comparator_control_asserts (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic [2:0]  comparator_on,
  input wire logic [5:0]  inverting_input_select,
  input wire logic [2:0]  noninverting_ref_select,
  input wire logic [2:0]  pin_normal_out,
  input wire logic [2:0]  output_pin_enable,
  input wire logic [2:0]  remappable_pin_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // New request, and a lane 0 write to control one
  wire q = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire w = q & wb_we_i & (wb_adr_i == 8'h00) & wb_sel_i[0];
  property p_ack; q |=> wb_ack_o ^ wb_err_o; endproperty
  property p_err; q && wb_adr_i > 8'h0C |=> wb_err_o; endproperty
  property p_on; w |=> comparator_on[0] == $past(wb_dat_i[7]); endproperty
  property p_sel; w |=> inverting_input_select[1:0] == $past(wb_dat_i[1:0]); endproperty
  property p_ref; w |=> noninverting_ref_select[0] == $past(wb_dat_i[2]); endproperty
  property p_oe; w |=> output_pin_enable[0] == $past(wb_dat_i[6]); endproperty
  property p_pin; !output_pin_enable[0] |=> remappable_pin_out[0] == $past(pin_normal_out[0]);
  endproperty
  property p_st; wb_ack_o && !wb_we_i && wb_adr_i == 8'h0C |-> wb_dat_o[31:3] == 29'h0;
  endproperty
  a_ack: assert property (p_ack) else $error("no single answer");
  a_err: assert property (p_err) else $error("unmapped not refused");
  a_on: assert property (p_on) else $error("enable wrong");
  a_sel: assert property (p_sel) else $error("minus select wrong");
  a_ref: assert property (p_ref) else $error("plus select wrong");
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  a_pin: assert property (p_pin) else $error("normal pin source lost");
  a_st: assert property (p_st) else $error("status spare bits set");
endmodule : analog_comparator_control_asserts
bind analog_comparator_control analog_comparator_control_asserts u_chk (.clk, .rstn,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .wb_err_o, .comparator_on, .inverting_input_select, .noninverting_ref_select,
  .pin_normal_out, .output_pin_enable, .remappable_pin_out);
`default_nettype wire

// ---- sim/test_analog_comparator_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_analog_comparator_control;
  logic        clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, er;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [4:0]  level;
  logic [23:0] raw;
  logic [2:0]  pin_normal_out, remappable_pin_out;
  int          fail_count, compares;
  // Control byte, source levels, expected status bit
  logic [13:0] rows [12] = '{14'h2001, 14'h2002, 14'h2043, 14'h2088, 14'h20D0, 14'h2100,
    14'h2121, 14'h2800, 14'h3001, 14'h3800, 14'h0801, 14'h0000};
  analog_source_model u_src (.level, .raw);
  analog_comparator_control u_dut (.clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .raw_gt_b(raw[2:0]),
    .raw_gt_c(raw[5:3]), .raw_gt_d(raw[8:6]), .raw_gt_fixed(raw[11:9]),
    .raw_ladder_gt_b(raw[14:12]), .raw_ladder_gt_c(raw[17:15]), .raw_ladder_gt_d(raw[20:18]),
    .raw_ladder_gt_fixed(raw[23:21]), .comparator_on(), .inverting_input_select(),
    .noninverting_ref_select(), .pin_normal_out, .output_pin_enable(), .remappable_pin_out);
  // One classic bus cycle, held until ack or err
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, adr, d};
    do @(posedge clk); while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1 && ++n < 50);
    {rd, er} = {wb_dat_o, wb_err_o};
    if (n >= 50) fail_count++;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : wb
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : check
  task automatic summarize();
    $display("Checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    summarize();
  end
  initial begin
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, level} = '0;
    pin_normal_out = 3'h5;
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    wb(1'h0, 8'h00, 32'h0);
    check("ctrl1 reset", 32'h0, rd);
    foreach (rows[i]) begin
      level <= rows[i][5:1];
      wb(1'h1, 8'h00, {24'h0, rows[i][13:6]});
      repeat (4) @(posedge clk);
      wb(1'h0, 8'h0C, 32'h0);
      check("status", {31'h0, rows[i][0]}, rd);
      check("pins", {29'h2, rows[i][12] ? rows[i][0] : 1'h1}, {29'h0, remappable_pin_out});
    end
    level <= 5'h08;
    wb(1'h1, 8'h04, 32'hFFFFFFFF);
    wb(1'h0, 8'h04, 32'h0);
    check("ctrl2 mask", 32'hE7, rd);
    wb(1'h1, 8'h0C, 32'hFF);
    wb(1'h0, 8'h0C, 32'h0);
    check("status ro", 32'h2, rd);
    check("pins", 32'h7, {29'h0, remappable_pin_out});
    wb(1'h0, 8'h10, 32'h0);
    check("unmapped", 32'h1, {31'h0, er});
    summarize();
  end
endmodule : test_analog_comparator_control
`default_nettype wire
